/* File: rtl/uat_cfg.svh */
// Operation
// - only full 32-bit ends use unaligned cycles
// - triple byte reads 0-2 and 1-3 supported
// - triple byte writes 0-2 and 1-3 supported
// - middle double byte read 1-2 supported
// - middle double byte write 1-2 supported
// - monitor flags triple/middle cycles on watched bytes
// - bytes 1-2 travel on lanes D08-D23
// - bytes 0-2 travel on lanes D08-D31
// - single bytes: odd on D00-D07, even D08-D15
// - aligned doubles on D00-D15, quad on D00-D31
// - master may split operand into single bytes
// - constituent cycles may come in any order
// - byte 1: lword high, A01 low, DS0 only
// - strobes held until acknowledge or bus error
`ifndef UAT_CFG_SVH
`define UAT_CFG_SVH
`define UAT_DATA_W 32
`define UAT_ADDR_W 8
`define UAT_MEM_AW 6
`define UAT_M_B0 4'h1
`define UAT_M_B1 4'h2
`define UAT_M_B2 4'h4
`define UAT_M_B3 4'h8
`define UAT_M_B01 4'h3
`define UAT_M_B23 4'hc
`define UAT_M_B12 4'h6
`define UAT_M_B02 4'h7
`define UAT_M_B13 4'he
`define UAT_M_B03 4'hf
`endif

/* File: rtl/uat_pkg.sv */
`include "uat_cfg.svh"
package uat_pkg;
  typedef logic [3:0] uat_mask_t;
  // strobe code seen on the backplane, strobes active low
  typedef struct packed {
    logic [1:0] ds_n;
    logic a01;
    logic lword_n;
  } uat_code_t;
  typedef struct packed {
    logic ok;
    uat_mask_t mask;
  } uat_dec_t;
  typedef struct packed {
    logic ok;
    uat_code_t code;
  } uat_enc_t;

  // strobe code to touched byte locations
  function automatic uat_dec_t uat_decode(uat_code_t c);
    uat_dec_t r;
    r = '{ok: 1'b1, mask: 4'h0};
    unique case ({c.ds_n, c.a01, c.lword_n})
      4'b0001: r.mask = `UAT_M_B01;
      4'b0011: r.mask = `UAT_M_B23;
      4'b0010: r.mask = `UAT_M_B12;
      4'b0000: r.mask = `UAT_M_B03;
      4'b0101: r.mask = `UAT_M_B0;
      4'b0111: r.mask = `UAT_M_B2;
      4'b0100: r.mask = `UAT_M_B02;
      4'b1001: r.mask = `UAT_M_B1;
      4'b1011: r.mask = `UAT_M_B3;
      4'b1000: r.mask = `UAT_M_B13;
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction : uat_decode

  // byte locations to strobe code, the inverse of the decoder
  function automatic uat_enc_t uat_encode(uat_mask_t m);
    uat_enc_t r;
    r = '{ok: 1'b1, code: 4'hf};
    unique case (m)
      `UAT_M_B01: r.code = 4'b0001;
      `UAT_M_B23: r.code = 4'b0011;
      `UAT_M_B12: r.code = 4'b0010;
      `UAT_M_B03: r.code = 4'b0000;
      `UAT_M_B0: r.code = 4'b0101;
      `UAT_M_B2: r.code = 4'b0111;
      `UAT_M_B02: r.code = 4'b0100;
      `UAT_M_B1: r.code = 4'b1001;
      `UAT_M_B3: r.code = 4'b1011;
      `UAT_M_B13: r.code = 4'b1000;
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction : uat_encode

  // lane of a location: longword cycles by 3-k, word cycles by 1-k[0]
  function automatic logic [1:0] uat_lane(logic lword_n, logic [1:0] loc);
    return lword_n ? {1'b0, ~loc[0]} : ~loc;
  endfunction : uat_lane
endpackage : uat_pkg

/* File: rtl/uat_if.sv */
`timescale 1ns/100ps
`include "uat_cfg.svh"
interface uat_if;
  logic as_n;
  logic [1:0] ds_n;
  logic lword_n;
  logic a01;
  logic [`UAT_ADDR_W-1:0] addr;
  logic write_n;
  logic [`UAT_DATA_W-1:0] m_d_out;
  logic m_d_oe;
  logic [`UAT_DATA_W-1:0] s_d_out;
  logic s_d_oe;
  logic [`UAT_DATA_W-1:0] d;
  logic dtack_n;
  logic berr_n;

  // resolved data wire; an undriven bus floats high through the terminators
  assign d = s_d_oe ? s_d_out : (m_d_oe ? m_d_out : '1);

  modport master (output as_n, ds_n, lword_n, a01, addr, write_n, m_d_out, m_d_oe,
                  input d, dtack_n, berr_n);
  modport slave (input as_n, ds_n, lword_n, a01, addr, write_n, d,
                 output s_d_out, s_d_oe, dtack_n, berr_n);
endinterface : uat_if

/* File: rtl/uat_master.sv */
`timescale 1ns/100ps
`include "uat_cfg.svh"
module uat_master #(
  parameter int DATA_W = `UAT_DATA_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // backplane
  uat_if.master bus,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`UAT_ADDR_W-1:0] req_addr,
  input wire uat_pkg::uat_mask_t req_mask,
  input wire logic [31:0] req_wdata,
  // answer
  output logic done,
  output logic done_err,
  output logic [31:0] rdata
);
  import uat_pkg::*;

  // only the two documented path widths are served
  if (DATA_W != 32 && DATA_W != 16) begin : g_bad_w
    $error("uat_master: DATA_W must be 16 or 32");
  end

  typedef enum {M_IDLE, M_ADDR, M_STRB, M_WAIT, M_REL} uat_mst_t;

  uat_mst_t st_ff, nxt_st;
  uat_code_t code_ff, nxt_code;
  logic [1:0] ds_n_ff, nxt_ds_n;
  logic as_n_ff, nxt_as_n;
  logic [`UAT_ADDR_W-1:0] addr_ff, nxt_addr;
  logic write_n_ff, nxt_write_n;
  logic [31:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe;
  logic done_ff, nxt_done;
  logic err_ff, nxt_err;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] sy1_ff, sy2_ff, sy3_ff, rsp_ff, nxt_rsp;
  uat_enc_t enc;
  uat_dec_t cur_dec;
  logic acked;
  logic idle_rsp;

  assign enc = uat_encode(req_mask);
  assign cur_dec = uat_decode(code_ff);
  assign acked = ~rsp_ff[1] | ~rsp_ff[0];
  assign idle_rsp = rsp_ff[1] & rsp_ff[0];
  assign req_ready = (st_ff == M_IDLE);

  // acknowledge lines pass three flops; a change counts when stages two and three agree
  always_comb begin
    nxt_rsp = rsp_ff;
    for (int i = 0; i < 2; i++) begin
      if (sy2_ff[i] == sy3_ff[i]) nxt_rsp[i] = sy3_ff[i];
    end
  end

  // cycle sequencer; the caller picks any split and any order of cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_ds_n = ds_n_ff;
    nxt_as_n = as_n_ff;
    nxt_addr = addr_ff;
    nxt_write_n = write_n_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_done = 1'b0;
    nxt_err = err_ff;
    nxt_rdata = rdata_ff;
    unique case (st_ff)
      M_IDLE: begin
        if (req_valid) begin
          // a narrow master never issues longword or unaligned cycles
          if (!enc.ok || (DATA_W != 32 && !enc.code.lword_n)) begin
            nxt_done = 1'b1;
            nxt_err = 1'b1;
          end else begin
            nxt_code = enc.code;
            nxt_addr = req_addr;
            nxt_write_n = ~req_write;
            nxt_err = 1'b0;
            nxt_dout = 32'h0000_0000;
            for (int k = 0; k < 4; k++) begin
              if (req_mask[k]) begin
                nxt_dout[8*uat_lane(enc.code.lword_n, 2'(k)) +: 8] = req_wdata[8*(3-k) +: 8];
              end
            end
            nxt_st = M_ADDR;
          end
        end
      end
      M_ADDR: begin
        // address had one cycle of setup; write data only once the last slave let go
        nxt_as_n = 1'b0;
        if (idle_rsp) begin
          nxt_doe = ~write_n_ff;
          nxt_st = M_STRB;
        end
      end
      M_STRB: begin
        if (idle_rsp) begin
          nxt_ds_n = code_ff.ds_n;
          nxt_st = M_WAIT;
        end
      end
      M_WAIT: begin
        // strobes stay low until an acknowledge or bus error arrives
        if (acked) begin
          nxt_err = ~rsp_ff[0];
          nxt_rdata = 32'h0000_0000;
          for (int k = 0; k < 4; k++) begin
            if (cur_dec.mask[k]) begin
              nxt_rdata[8*(3-k) +: 8] = bus.d[8*uat_lane(code_ff.lword_n, 2'(k)) +: 8];
            end
          end
          nxt_ds_n = 2'b11;
          nxt_as_n = 1'b1;
          nxt_doe = 1'b0;
          nxt_st = M_REL;
        end
      end
      M_REL: begin
        if (idle_rsp) begin
          nxt_done = 1'b1;
          nxt_st = M_IDLE;
        end
      end
    endcase
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff <= M_IDLE;
      code_ff <= 4'hf;
      ds_n_ff <= 2'b11;
      as_n_ff <= 1'b1;
      addr_ff <= '0;
      write_n_ff <= 1'b1;
      dout_ff <= 32'h0000_0000;
      doe_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      sy1_ff <= 2'b11;
      sy2_ff <= 2'b11;
      sy3_ff <= 2'b11;
      rsp_ff <= 2'b11;
    end else begin
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      ds_n_ff <= nxt_ds_n;
      as_n_ff <= nxt_as_n;
      addr_ff <= nxt_addr;
      write_n_ff <= nxt_write_n;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      rdata_ff <= nxt_rdata;
      sy1_ff <= {bus.dtack_n, bus.berr_n};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      rsp_ff <= nxt_rsp;
    end
  end

  assign bus.as_n = as_n_ff;
  assign bus.ds_n = ds_n_ff;
  assign bus.lword_n = code_ff.lword_n;
  assign bus.a01 = code_ff.a01;
  assign bus.addr = addr_ff;
  assign bus.write_n = write_n_ff;
  assign bus.m_d_out = dout_ff;
  assign bus.m_d_oe = doe_ff;
  assign done = done_ff;
  assign done_err = err_ff;
  assign rdata = rdata_ff;
endmodule : uat_master

/* File: rtl/uat_slave.sv */
`timescale 1ns/100ps
`include "uat_cfg.svh"
module uat_slave #(
  parameter int DATA_W = `UAT_DATA_W,
  parameter int MEM_AW = `UAT_MEM_AW
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // backplane
  uat_if.slave bus,
  // location monitor setup
  input wire logic [`UAT_ADDR_W-1:0] mon_addr,
  input wire uat_pkg::uat_mask_t mon_mask,
  // location monitor events
  output logic mon_rd,
  output logic mon_wr,
  // status
  output logic bad_cycle,
  output logic busy
);
  import uat_pkg::*;

  // only the two documented path widths and a store inside the address range are served
  if (DATA_W != 32 && DATA_W != 16) begin : g_bad_w
    $error("uat_slave: DATA_W must be 16 or 32");
  end
  if (MEM_AW < 1 || MEM_AW > `UAT_ADDR_W) begin : g_bad_aw
    $error("uat_slave: MEM_AW out of range");
  end

  localparam int DEPTH = 1 << MEM_AW;

  typedef enum {S_IDLE, S_SETL, S_ACK, S_REL, S_IGN} uat_slv_t;

  uat_slv_t st_ff, nxt_st;
  logic [2:0] sy1_ff, sy2_ff, sy3_ff, stb_ff, nxt_stb;
  logic dtack_n_ff, nxt_dtack_n;
  logic [31:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe;
  logic mon_rd_ff, nxt_mon_rd;
  logic mon_wr_ff, nxt_mon_wr;
  logic bad_ff, nxt_bad;
  uat_code_t code;
  uat_dec_t dec;
  logic cyc_ok;
  logic in_range;
  logic claim;
  logic strobed;
  logic released;
  logic [3:0] we;
  logic [1:0] lane [4];
  logic [7:0] rd_byte [4];

  // filtered strobes: {as_n, ds_n[1], ds_n[0]}
  assign strobed = ~stb_ff[2] & ~(stb_ff[1] & stb_ff[0]);
  assign released = stb_ff[1] & stb_ff[0];

  // address lines have been stable since before the strobes, so they are read direct
  assign code = '{ds_n: stb_ff[1:0], a01: bus.a01, lword_n: bus.lword_n};
  assign dec = uat_decode(code);
  // a narrow slave never claims a longword or unaligned cycle
  assign cyc_ok = dec.ok && (DATA_W == 32 || code.lword_n);
  assign in_range = (bus.addr >> MEM_AW) == '0;
  assign claim = cyc_ok && in_range;

  // strobe inputs pass three flops; a change counts when stages two and three agree
  always_comb begin
    nxt_stb = stb_ff;
    for (int i = 0; i < 3; i++) begin
      if (sy2_ff[i] == sy3_ff[i]) nxt_stb[i] = sy3_ff[i];
    end
  end

  // one storage column per byte location, each with its own lane
  for (genvar k = 0; k < 4; k++) begin : g_loc
    logic [7:0] mem [DEPTH];

    // longword cycles put location k on lane 3-k, word cycles on lane 1-k[0]
    assign lane[k] = uat_lane(code.lword_n, 2'(k));
    assign rd_byte[k] = mem[bus.addr[MEM_AW-1:0]];
    assign we[k] = (st_ff == S_SETL) && claim && !bus.write_n && dec.mask[k];

    // storage has no reset; contents are undefined until written
    always_ff @(posedge ref_clk) begin
      if (we[k]) begin
        mem[bus.addr[MEM_AW-1:0]] <= bus.d[8*lane[k] +: 8];
      end
    end
  end

  // cycle responder
  always_comb begin
    nxt_st = st_ff;
    nxt_dtack_n = dtack_n_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_mon_rd = 1'b0;
    nxt_mon_wr = 1'b0;
    nxt_bad = 1'b0;
    unique case (st_ff)
      S_IDLE: begin
        if (strobed) nxt_st = S_SETL;
      end
      S_SETL: begin
        // one cycle of grace lets a skewed second data strobe arrive before decode
        if (cyc_ok && bus.addr == mon_addr && |(dec.mask & mon_mask)) begin
          nxt_mon_rd = bus.write_n;
          nxt_mon_wr = ~bus.write_n;
        end
        // every listed pattern is accepted in whatever order it comes
        if (claim) begin
          nxt_dout = 32'h0000_0000;
          for (int k = 0; k < 4; k++) begin
            if (dec.mask[k]) nxt_dout[8*lane[k] +: 8] = rd_byte[k];
          end
          nxt_doe = bus.write_n;
          nxt_dtack_n = 1'b0;
          nxt_st = S_ACK;
        end else begin
          // unsupported or foreign cycles are left for the bus timer
          nxt_bad = ~cyc_ok;
          nxt_st = S_IGN;
        end
      end
      S_ACK: begin
        // data holds until the master lifts its strobes, then leaves before dtack does
        if (released) begin
          nxt_doe = 1'b0;
          nxt_st = S_REL;
        end
      end
      S_REL: begin
        nxt_dtack_n = 1'b1;
        nxt_st = S_IDLE;
      end
      S_IGN: begin
        if (released) nxt_st = S_IDLE;
      end
    endcase
  end

  // register stage
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff <= S_IDLE;
      sy1_ff <= 3'h7;
      sy2_ff <= 3'h7;
      sy3_ff <= 3'h7;
      stb_ff <= 3'h7;
      dtack_n_ff <= 1'b1;
      dout_ff <= 32'h0000_0000;
      doe_ff <= 1'b0;
      mon_rd_ff <= 1'b0;
      mon_wr_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sy1_ff <= {bus.as_n, bus.ds_n};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      stb_ff <= nxt_stb;
      dtack_n_ff <= nxt_dtack_n;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      mon_rd_ff <= nxt_mon_rd;
      mon_wr_ff <= nxt_mon_wr;
      bad_ff <= nxt_bad;
    end
  end

  // this end never signals bus error; a stuck cycle is the bus timer's job
  assign bus.berr_n = 1'b1;
  assign bus.dtack_n = dtack_n_ff;
  assign bus.s_d_out = dout_ff;
  assign bus.s_d_oe = doe_ff;
  assign mon_rd = mon_rd_ff;
  assign mon_wr = mon_wr_ff;
  assign bad_cycle = bad_ff;
  assign busy = (st_ff != S_IDLE);
endmodule : uat_slave

/* File: testbench/uat_bus_monitor.sv */
`timescale 1ns/100ps
`include "uat_cfg.svh"
module uat_bus_monitor (
  // clock and reset
  input logic ref_clk,
  input logic resetn,
  // backplane
  input logic as_n,
  input logic [1:0] ds_n,
  input logic lword_n,
  input logic a01,
  input logic [`UAT_ADDR_W-1:0] addr,
  input logic write_n,
  input logic m_d_oe,
  input logic s_d_oe,
  input logic dtack_n,
  input logic berr_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // strobe protocol; the slave store range is kept by the bench, so ack is bounded
  a_strobe_hold: assert property (
    (ds_n != 2'b11 && dtack_n && berr_n) |=> ds_n == $past(ds_n))
    else $error("strobes moved before acknowledge");
  a_pattern_legal: assert property (
    ds_n != 2'b11 |-> {ds_n, a01, lword_n} inside {4'b0001, 4'b0011, 4'b0010,
      4'b0000, 4'b0101, 4'b0111, 4'b0100, 4'b1001, 4'b1011, 4'b1000})
    else $error("unlisted strobe pattern");
  a_as_before_ds: assert property (ds_n != 2'b11 |-> !as_n)
    else $error("data strobe without address strobe");
  a_ack_bounded: assert property ($fell(&ds_n) |-> ##[1:20] !dtack_n)
    else $error("no acknowledge");
  a_release_bounded: assert property (
    $fell(dtack_n) |-> ##[1:10] (ds_n == 2'b11 && as_n))
    else $error("strobes not released");
  a_mwrite_only: assert property (m_d_oe |-> !write_n && !as_n)
    else $error("master drives data outside write");
  a_sread_only: assert property (s_d_oe |-> write_n && !m_d_oe)
    else $error("slave drives data outside read");
  a_addr_stable: assert property (
    ($past(ds_n) != 2'b11 && ds_n != 2'b11) |-> $stable({addr, a01, lword_n, write_n}))
    else $error("address moved in strobe");
  // main cycle kinds seen acknowledged
  c_quad: cover property (!dtack_n && {ds_n, a01, lword_n} == 4'b0000);
  c_tri: cover property (!dtack_n && {ds_n, a01, lword_n} == 4'b0100);
  c_mid: cover property (!dtack_n && {ds_n, a01, lword_n} == 4'b0010);
  c_odd: cover property (!dtack_n && {ds_n, a01, lword_n} == 4'b1001);
endmodule : uat_bus_monitor

/* File: testbench/unaligned_byte_lane_transfer_bench.sv */
`timescale 1ns/100ps
`include "uat_cfg.svh"
module unaligned_byte_lane_transfer_bench;
  import uat_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  uat_mask_t req_mask = 4'h0;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic [7:0] mon_addr = 8'h00;
  uat_mask_t mon_mask = 4'h0;
  logic req_ready, done, done_err, mon_rd, mon_wr, bad_cycle, busy;
  logic [31:0] rdata;
  int errors = 0;
  int check_count = 0;
  logic [7:0] shadow [0:7][0:3];
  uat_mask_t legal [10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h6, 4'h7, 4'he, 4'hf};
  uat_mask_t unlisted [6] = '{4'h0, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd};

  uat_if bus ();
  uat_master uat_master_i (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_mask(req_mask), .req_wdata(req_wdata),
    .done(done), .done_err(done_err), .rdata(rdata));
  uat_slave uat_slave_i (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
    .mon_addr(mon_addr), .mon_mask(mon_mask), .mon_rd(mon_rd), .mon_wr(mon_wr),
    .bad_cycle(bad_cycle), .busy(busy));
  uat_bus_monitor uat_bus_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
    .as_n(bus.as_n), .ds_n(bus.ds_n), .lword_n(bus.lword_n), .a01(bus.a01),
    .addr(bus.addr), .write_n(bus.write_n), .m_d_oe(bus.m_d_oe), .s_d_oe(bus.s_d_oe),
    .dtack_n(bus.dtack_n), .berr_n(bus.berr_n));

  always #5 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  // longword cycles put location k on lane 3-k, word cycles on lane 1-k[0]
  function automatic logic [31:0] lanes(uat_mask_t m, logic [31:0] v);
    logic lw;
    lanes = 32'h0000_0000;
    lw = m inside {4'h6, 4'h7, 4'he, 4'hf};
    for (int k = 0; k < 4; k++)
      if (m[k]) lanes[8*(lw ? 3 - k : 1 - k % 2)+:8] = v[8*(3-k)+:8];
  endfunction : lanes

  // one request; the wire is checked while strobes and acknowledge are both low
  task automatic xfer(input logic wr, input logic [7:0] a, input uat_mask_t m,
                      input logic [31:0] wd, input logic bad);
    logic [31:0] exp;
    logic [31:0] lm;
    logic hit, srd, swr, sbad, sbusy;
    int n;
    exp = 32'h0000_0000;
    sbusy = 1'b0;
    lm = lanes(m, 32'hffff_ffff);
    hit = !bad && a == mon_addr && (m & mon_mask) != 4'h0;
    {srd, swr, sbad} = 3'b000;
    for (int k = 0; k < 4; k++)
      if (m[k] && !bad) begin
        if (wr) shadow[a][k] = wd[8*(3-k)+:8];
        exp[8*(3-k)+:8] = shadow[a][k];
      end
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (req_ready !== 1'b1) begin
      check(1'b0, "ready timeout");
      tally_and_finish();
    end
    {req_valid, req_write, req_addr, req_mask, req_wdata} = {1'b1, wr, a, m, wd};
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      if (bus.dtack_n === 1'b0 && bus.ds_n !== 2'b11)
        check((bus.d & lm) === lanes(m, exp), "lane mismatch");
      {srd, swr, sbad} = {srd | mon_rd, swr | mon_wr, sbad | bad_cycle};
      sbusy = sbusy | busy;
      @(posedge ref_clk);
      #1 n++;
    end
    if (done !== 1'b1) begin
      check(1'b0, "timeout");
      tally_and_finish();
    end else begin
      check(done_err === bad, "completion status");
      check({sbusy, busy} === {!bad, 1'b0}, "slave activity");
      check({srd, swr, sbad} === {hit & !wr, hit & wr, 1'b0}, "monitor pulses");
      if (!wr && !bad) check(rdata === exp, "read data");
    end
  endtask : xfer

  // reset, then listed patterns, a split operand, refusals and random traffic
  initial begin
    logic [7:0] a;
    void'($urandom(32'hfab53932));
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 8; i++) xfer(1'b1, 8'(i), 4'hf, $urandom, 1'b0);
    mon_addr = 8'h03;
    mon_mask = 4'h6;
    for (int i = 0; i < 10; i++) begin
      xfer(1'b1, 8'h03, legal[i], $urandom, 1'b0);
      xfer(1'b0, 8'h03, legal[i], 32'h0000_0000, 1'b0);
    end
    // descending single bytes, then the whole word back in one cycle
    for (int k = 3; k >= 0; k--) xfer(1'b1, 8'h05, 4'(1 << k), $urandom, 1'b0);
    xfer(1'b0, 8'h05, 4'hf, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 6; i++) xfer(1'($urandom), 8'h02, unlisted[i], $urandom, 1'b1);
    repeat (80) begin
      a = 8'($urandom_range(7));
      mon_mask = 4'($urandom);
      xfer(1'($urandom), a, legal[$urandom_range(9)], $urandom, 1'b0);
    end
    tally_and_finish();
  end
endmodule : unaligned_byte_lane_transfer_bench
